// File: core/pmrc_regs.svh
// Register offsets, field positions, reset values and timing counts
//
// Behaviour
// - After power-up the device sits idle with every sensing function off.
// - Setting the run bit in the power state register starts measurement.
// - Clearing the run bit returns the device from active to idle.
// - Sensing functions are off while idle and available once active.
// - Rate register bit 4 selects a reduced internal sampling rate.
// - Reduced sampling takes effect only for output rates 12.5 Hz to 400 Hz.
// - Code 1111 gives 3200 Hz; each step down halves the output rate.
// - Signal bandwidth is half the selected output data rate.
// - The run bit is bit 3 of the power state register.
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PMRC_ADDR_W       6
`define PMRC_ADDR_RATE    6'h2C
`define PMRC_ADDR_PWR     6'h2D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMRC_RUN_BIT      3
`define PMRC_LOWPWR_BIT   4
`define PMRC_CODE_MSB     3

// ----------------------------------------------------------------
// Reset values and code limits
// ----------------------------------------------------------------
`define PMRC_RATE_RST     5'h0A
`define PMRC_PWR_RST      8'h00
`define PMRC_CODE_MAX     4'hF
`define PMRC_LP_CODE_MIN  4'h7
`define PMRC_LP_CODE_MAX  4'hC

// ----------------------------------------------------------------
// Timing: 250 MHz clock, 3200 Hz fastest output rate
// ----------------------------------------------------------------
`define PMRC_CLK_HZ       32'h0EE6B280
`define PMRC_ODR_MAX_HZ   32'h00000C80
`define PMRC_BASE_CYCLES  (`PMRC_CLK_HZ / `PMRC_ODR_MAX_HZ)

`endif

// File: core/pmrc_pkg.sv
// Types shared by the power mode and rate control block
package pmrc_pkg;

    // Applied rate settings
    typedef struct packed {
        logic       lowpwr;
        logic [3:0] code;
    } pmrc_rate_s;

    // Operating state, one-hot
    typedef enum logic [1:0] {
        PMRC_IDLE   = 2'b01,
        PMRC_ACTIVE = 2'b10
    } pmrc_state_e;

endpackage

// File: core/pmrc_rate_gen.sv
// Sample period divider producing period and half-period strobes
`timescale 1ns/100ps
module pmrc_rate_gen (
    input  wire logic        i_clk,     // System clock
    input  wire logic        i_sys_rst, // Synchronous reset, high
    input  wire logic        i_en,      // Count while high
    input  wire logic [31:0] i_period,  // Period in clock cycles
    output logic             o_tick,    // Last cycle of the period
    output logic             o_half     // Last cycle of first half
);
    logic [31:0] cnt_reg;
    logic [31:0] last;
    logic [31:0] half_last;

    assign last      = i_period - 32'h00000001;
    assign half_last = (i_period >> 1) - 32'h00000001;

    // Free counter, restarted whenever counting is disabled
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !i_en) begin
            cnt_reg <= 32'h00000000;
        end else if (cnt_reg >= last) begin
            cnt_reg <= 32'h00000000;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
        end
    end

    assign o_tick = i_en && (cnt_reg == last);
    assign o_half = i_en && (cnt_reg == half_last);
endmodule

// File: core/pmrc_top.sv
// Power state and output rate control of the acceleration sensor
`timescale 1ns/100ps
`include "pmrc_regs.svh"
module pmrc_top
    import pmrc_pkg::*;
#(
    parameter logic [31:0] P_BASE_CYCLES = `PMRC_BASE_CYCLES // 3200 Hz
) (
    input  wire logic                    i_clk,       // 250 MHz clock
    input  wire logic                    i_sys_rst,   // Sync reset, high
    input  wire logic                    i_reg_wr,    // Register write
    input  wire logic                    i_reg_rd,    // Register read
    input  wire logic [`PMRC_ADDR_W-1:0] i_reg_addr,  // Register offset
    input  wire logic [7:0]              i_reg_wdata, // Write data
    output logic      [7:0]              o_reg_rdata, // Read data
    output logic                         o_sense_en,  // Sensing enabled
    output logic                         o_sample_tick, // Output sample
    output logic                         o_int_tick,  // Internal sample
    output logic                         o_lowpwr_eff, // Reduced rate on
    output logic      [3:0]              o_odr_code,  // Applied rate code
    output logic      [3:0]              o_bw_shift   // 1600 Hz >> shift
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [4:0]  rate_reg;
    logic [7:0]  pwr_reg;
    pmrc_state_e state_reg;
    pmrc_state_e state_next;
    pmrc_rate_s  applied_reg;
    logic        wr_rate;
    logic        wr_pwr;
    logic        active;
    logic        lp_eff;
    logic [31:0] period;
    logic        tick_c;
    logic        half_c;

    assign wr_rate = i_reg_wr && (i_reg_addr == `PMRC_ADDR_RATE);
    assign wr_pwr  = i_reg_wr && (i_reg_addr == `PMRC_ADDR_PWR);
    assign active  = (state_reg == PMRC_ACTIVE);

    // Rate register: low power flag and code; upper bits read zero
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rate_reg <= `PMRC_RATE_RST;
        end else if (wr_rate) begin
            rate_reg <= i_reg_wdata[4:0];
        end
    end

    // Power state register, all bits kept for readback
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pwr_reg <= `PMRC_PWR_RST;
        end else if (wr_pwr) begin
            pwr_reg <= i_reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Idle / active sequencing
    // ----------------------------------------------------------------
    // Only a write to the power register moves the state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PMRC_IDLE: begin
                if (wr_pwr && i_reg_wdata[`PMRC_RUN_BIT]) begin
                    state_next = PMRC_ACTIVE;
                end
            end
            PMRC_ACTIVE: begin
                if (wr_pwr && !i_reg_wdata[`PMRC_RUN_BIT]) begin
                    state_next = PMRC_IDLE;
                end
            end
            default: begin
                state_next = PMRC_IDLE;
            end
        endcase
    end

    // Reset stands for main supply coming up: always idle afterwards
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg <= PMRC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Rate application
    // ----------------------------------------------------------------
    // Idle follows the register; active waits for the period end so a
    // running sample period is never cut short by a new code
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            applied_reg <= pmrc_rate_s'(`PMRC_RATE_RST);
        end else if (!active || tick_c) begin
            applied_reg.lowpwr <= rate_reg[`PMRC_LOWPWR_BIT];
            applied_reg.code   <= rate_reg[`PMRC_CODE_MSB:0];
        end
    end

    // Each code step down doubles the period
    assign period = P_BASE_CYCLES << (`PMRC_CODE_MAX - applied_reg.code);

    // Reduced sampling only pays off between 12.5 Hz and 400 Hz
    assign lp_eff = applied_reg.lowpwr
                 && (applied_reg.code >= `PMRC_LP_CODE_MIN)
                 && (applied_reg.code <= `PMRC_LP_CODE_MAX);

    pmrc_rate_gen u_rate_gen (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_en      (active),
        .i_period  (period),
        .o_tick    (tick_c),
        .o_half    (half_c)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Internal sampling runs at twice the output rate, or at the output
    // rate alone in reduced mode: less current, slightly more noise
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_sense_en    <= 1'b0;
            o_sample_tick <= 1'b0;
            o_int_tick    <= 1'b0;
            o_lowpwr_eff  <= 1'b0;
        end else begin
            o_sense_en    <= (state_next == PMRC_ACTIVE);
            o_sample_tick <= active && tick_c;
            o_int_tick    <= active && (tick_c || (half_c && !lp_eff));
            o_lowpwr_eff  <= lp_eff;
        end
    end

    // Bandwidth is one step below the output rate on the same scale
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_odr_code <= 4'(`PMRC_RATE_RST);
            o_bw_shift <= `PMRC_CODE_MAX - 4'(`PMRC_RATE_RST);
        end else begin
            o_odr_code <= applied_reg.code;
            o_bw_shift <= `PMRC_CODE_MAX - applied_reg.code;
        end
    end

    // Read port; unmapped offsets return zero
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `PMRC_ADDR_RATE: o_reg_rdata <= {3'h0, rate_reg};
                `PMRC_ADDR_PWR:  o_reg_rdata <= pwr_reg;
                default:         o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Helper: cycles since the last period end while active
    logic [31:0] h_gap;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !active || tick_c) begin
            h_gap <= 32'h00000001;
        end else begin
            h_gap <= h_gap + 32'h00000001;
        end
    end

    sequence s_run_write;
        wr_pwr && i_reg_wdata[`PMRC_RUN_BIT];
    endsequence

    sequence s_stop_write;
        wr_pwr && !i_reg_wdata[`PMRC_RUN_BIT];
    endsequence

    property p_idle_at_start;
        @(posedge i_clk) disable iff (i_sys_rst)
        $fell(i_sys_rst) |-> !o_sense_en && !active;
    endproperty
    a_idle_at_start: assert property (p_idle_at_start)
        else $error("not idle after reset");

    property p_stay_idle;
        @(posedge i_clk) disable iff (i_sys_rst)
        !active && !(wr_pwr && i_reg_wdata[`PMRC_RUN_BIT]) |=> !active;
    endproperty
    a_stay_idle: assert property (p_stay_idle)
        else $error("left idle without run write");

    property p_run_starts;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_run_write |=> o_sense_en && active;
    endproperty
    a_run_starts: assert property (p_run_starts)
        else $error("run write did not start measuring");

    property p_stop_returns;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_stop_write |=> !o_sense_en ##1 !o_sample_tick;
    endproperty
    a_stop_returns: assert property (p_stop_returns)
        else $error("clearing run did not return to idle");

    property p_no_sense_idle;
        @(posedge i_clk) disable iff (i_sys_rst)
        !o_sense_en ##1 !o_sense_en |-> !o_sample_tick && !o_int_tick;
    endproperty
    a_no_sense_idle: assert property (p_no_sense_idle)
        else $error("sampling while idle");

    property p_reduced_ticks;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_int_tick && o_lowpwr_eff && $past(o_lowpwr_eff) |-> o_sample_tick;
    endproperty
    a_reduced_ticks: assert property (p_reduced_ticks)
        else $error("extra internal sample in reduced mode");

    property p_reduced_range;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_lowpwr_eff |-> o_odr_code >= `PMRC_LP_CODE_MIN
                      && o_odr_code <= `PMRC_LP_CODE_MAX;
    endproperty
    a_reduced_range: assert property (p_reduced_range)
        else $error("reduced mode outside its rate range");

    property p_period_len;
        @(posedge i_clk) disable iff (i_sys_rst)
        tick_c |-> h_gap == period;
    endproperty
    a_period_len: assert property (p_period_len)
        else $error("sample period length wrong");

    property p_bandwidth;
        @(posedge i_clk) disable iff (i_sys_rst)
        1'b1 |=> o_bw_shift == `PMRC_CODE_MAX - $past(applied_reg.code);
    endproperty
    a_bandwidth: assert property (p_bandwidth)
        else $error("bandwidth not half the output rate");

    property p_code_on_period;
        @(posedge i_clk) disable iff (i_sys_rst)
        active && $past(active) && $changed(applied_reg) |-> $past(tick_c);
    endproperty
    a_code_on_period: assert property (p_code_on_period)
        else $error("rate changed inside a sample period");
endmodule

// File: verif/pmrc_host_model.sv
// Host model that drives the register strobe port of the block
`timescale 1ns/100ps
module pmrc_host_model (
    input  wire logic       i_clk,       // System clock
    output logic            o_reg_wr,    // Write strobe
    output logic            o_reg_rd,    // Read strobe
    output logic [5:0]      o_reg_addr,  // Register offset
    output logic [7:0]      o_reg_wdata, // Write data
    input  wire logic [7:0] i_reg_rdata  // Read data
);
    // ------------------------------------------------
    // Bus idle at time zero
    // ------------------------------------------------
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = 6'h00;
        o_reg_wdata = 8'h00;
    end

    // Single byte write; released lines are inverted so stale data never
    // passes for a fresh value
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg_wr    <= 1'b1;
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        @(posedge i_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
    endtask

    // Single byte read; data is taken once the answer edge has landed
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_reg_rd   <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~a;
        #1;
        d = i_reg_rdata;
    endtask
endmodule

// File: verif/pmrc_tb_top.sv
// Self-checking bench for the power mode and rate control block
`timescale 1ns/100ps
`include "pmrc_regs.svh"
module pmrc_tb_top;
    localparam logic [31:0] P_BASE = 32'h4; // Short base period
    logic       i_clk;
    logic       i_sys_rst;
    logic       reg_wr;
    logic       reg_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] rdata;
    logic       sense_en;
    logic       s_tick;
    logic       i_tick;
    logic       lp_eff;
    logic [3:0] odr;
    logic [3:0] bw;
    logic       prev_en = 1'b0;
    int         n_mismatch;
    int         tests_run;
    int         idle_ticks = 0;
    int         cyc = 0;
    int         m_rate;
    int         m_pwr;

    pmrc_top #(.P_BASE_CYCLES(P_BASE)) DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(rdata), .o_sense_en(sense_en), .o_sample_tick(s_tick),
        .o_int_tick(i_tick), .o_lowpwr_eff(lp_eff), .o_odr_code(odr),
        .o_bw_shift(bw));

    pmrc_host_model HOST (
        .i_clk(i_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(rdata));

    // ------------------------------------------------
    // Clock, idle tick watch and hang guard
    // ------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Two idle cycles in a row so the drop of the run bit is not counted
    always @(posedge i_clk) begin
        if (sense_en === 1'b0 && prev_en === 1'b0 && (s_tick | i_tick) !== 1'b0)
            idle_ticks++;
        prev_en <= sense_en;
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------
    function automatic int exp_lp();
        return m_rate[4] && m_rate[3:0] >= 7 && m_rate[3:0] <= 12;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_out();
        chk(sense_en, m_pwr[3]);
        chk(odr, m_rate[3:0]);
        chk(bw, 15 - m_rate[3:0]);
        if (m_pwr[3])
            chk(lp_eff, exp_lp());
    endtask

    // Cycles from one output sample to the next, and internal strobes seen
    task automatic measure(output int per, output int ints);
        int w;
        per = 0;
        ints = 0;
        w = 0;
        while (s_tick !== 1'b1 && w < 20000) begin
            @(posedge i_clk);
            #1;
            w++;
        end
        do begin
            @(posedge i_clk);
            #1;
            per++;
            if (i_tick === 1'b1)
                ints++;
        end while (s_tick !== 1'b1 && per < 20000);
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        logic [7:0] d;
        int         per;
        int         ints;
        int         codes[4];
        codes = '{15, 12, 8, 5};
        n_mismatch = 0;
        tests_run = 0;
        m_rate = 8'h0A;
        m_pwr = 0;
        void'($urandom(15005));
        i_sys_rst = 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk(rdata, 8'h00);
        chk_out();
        HOST.rd(`PMRC_ADDR_RATE, d);
        chk(d, 8'h0A);
        HOST.rd(`PMRC_ADDR_PWR, d);
        chk(d, 8'h00);
        HOST.wr(6'h2E, 8'h5A);
        HOST.rd(6'h2E, d);
        chk(d, 8'h00);
        // Every rate code while idle, random reduced flag, upper bits set
        for (int c = 0; c < 16; c++) begin
            m_rate = ($urandom % 2) * 16 + c;
            HOST.wr(`PMRC_ADDR_RATE, 8'(m_rate) | 8'hE0);
            repeat (4) @(posedge i_clk);
            #1;
            chk_out();
            HOST.rd(`PMRC_ADDR_RATE, d);
            chk(d, m_rate);
        end
        // Active runs: period and internal strobes per code
        for (int k = 0; k < 4; k++) begin
            m_rate = codes[k] + ((k != 2) ? 16 : 0);
            HOST.wr(`PMRC_ADDR_RATE, 8'(m_rate));
            m_pwr = 8'h08;
            HOST.wr(`PMRC_ADDR_PWR, 8'h08);
            repeat (3) @(posedge i_clk);
            #1;
            chk_out();
            measure(per, ints);
            measure(per, ints);
            chk(per, P_BASE << (15 - codes[k]));
            chk(ints, exp_lp() ? 1 : 2);
            m_pwr = $urandom & 8'hF7;
            HOST.wr(`PMRC_ADDR_PWR, 8'(m_pwr));
            repeat (3) @(posedge i_clk);
            #1;
            chk_out();
            HOST.rd(`PMRC_ADDR_PWR, d);
            chk(d, m_pwr);
        end
        // New code written while active waits for the running period end
        m_rate = 8;
        HOST.wr(`PMRC_ADDR_RATE, 8'(m_rate));
        m_pwr = 8'h08;
        HOST.wr(`PMRC_ADDR_PWR, 8'h08);
        measure(per, ints);
        HOST.wr(`PMRC_ADDR_RATE, 8'h19);
        repeat (2) @(posedge i_clk);
        #1;
        chk(odr, m_rate);
        m_rate = 8'h19;
        measure(per, ints);
        measure(per, ints);
        chk(per, P_BASE << 6);
        chk(ints, 1);
        chk_out();
        // Reset in mid-run drops back to idle with reset values
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        m_rate = 8'h0A;
        m_pwr = 0;
        #1;
        chk_out();
        HOST.rd(`PMRC_ADDR_PWR, d);
        chk(d, 8'h00);
        HOST.rd(`PMRC_ADDR_RATE, d);
        chk(d, 8'h0A);
        repeat (50) @(posedge i_clk);
        chk(idle_ticks, 0);
        wrap_up();
    end
endmodule
